/* File: common/usart_sync_map.svh */
// Overview of operation
// RULE1 - Synchronous slave takes transfer clock as input; master drives it out.
// RULE2 - Input sampled on the transfer clock edge opposite the output change edge.
// RULE3 - Polarity clear: change on rising, sample on falling; set swaps them.
// RULE4 - All thirty formats: five to nine data, parity none/even/odd, one/two stops.
// RULE5 - Start, data LSB first, optional parity, then stop bits.
// RULE6 - Start low, stops high, line high when idle.
// RULE7 - After a frame, next frame follows at once or line idles high.
// RULE8 - Three-bit character size field sets data bits for both directions.
// RULE9 - Two-bit parity mode field enables parity and picks even or odd.
// RULE10 - Stop select picks one or two stops; receiver checks only the first.
// RULE11 - One shared format; change it only while both directions idle.
// RULE12 - Frame error flagged only when first sampled stop bit is zero.
// RULE13 - Parity is XOR of data bits, inverted for odd.
// RULE14 - Software reprograms rate or format only when idle and drained.
// RULE15 - Software clears transmit complete before each data write if used.
// RULE16 - Transmit enable hands the serial output pin to the transmitter.
// RULE17 - Synchronous with transmitter enabled, clock pin becomes transfer clock.
// RULE18 - Writing the data buffer loads it and starts transmission.
// RULE19 - Buffer moves to shifter when idle or right after last stop bit.
// RULE20 - Shifter sends a whole frame at divisor rate or external clock rate.
// RULE21 - Unused upper data bits ignored for sizes below eight.
// RULE22 - Buffer empty flag shown; software waits for it before writing.
// RULE23 - Baud down-counter reloads at zero or low-byte write; divide 2/8/16.
// RULE24 - Double speed in asynchronous mode divides by eight instead of sixteen.
// RULE25 - Data write clears buffer empty until moved into shifter.
// RULE26 - Ninth bit is written before the low byte for nine-bit characters.
// RULE27 - Enabled transmitter with no frame keeps output high.
`ifndef USART_SYNC_MAP_SVH
`define USART_SYNC_MAP_SVH
`define ADDR_DATA 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_CTRL 12'h008
`define ADDR_FORMAT 12'h00C
`define ADDR_BAUD 12'h010
`define ST_BUFEMPTY 0
`define ST_TXC 1
`define ST_RXC 2
`define ST_FE 3
`define ST_DBL 4
`define CT_TRANSMIT_ENABLE_BIT 0
`define CT_RXEN 1
`define CT_NINTH 2
`define CT_MASTER 3
`define FM_SIZE_LO 0
`define FM_PAR_LO 3
`define FM_STOP 5
`define FM_SYNC 6
`define FM_POL 7
`define SIZE_NINE 3'h7
`define SIZE_RESET 3'h3
`define DIV_ASYNC 5'h10
`define DIV_DOUBLE 5'h08
`define DIV_SYNC 5'h02
`define BAUD_RESET 12'h000
`endif

/* File: common/usart_sync_pkg.sv */
package usart_sync_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_BITS = 4'b0100,
        TX_STOP = 4'b1000
    } tx_state_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_BITS = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;
endpackage

/* File: design/usart_sync_framing_tx.sv */
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "usart_sync_map.svh"
module usart_sync_framing_tx #(
    parameter int BAUD_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire usart_sync_pkg::word_t pwdata,
    output usart_sync_pkg::word_t prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins
    input wire logic serialInPin,
    output logic serialOutPin,
    output logic serialOutOe,
    input wire logic xferClockIn,
    output logic xferClockOut,
    output logic xferClockOe
);
    import usart_sync_pkg::*;

    // Divisor readback is zero-extended into one 32-bit word
    if (BAUD_W < 1 || BAUD_W > 16) begin : gBadBaudW
        $error("BAUD_W out of range");
    end

    // ======================================================
    // Helpers
    function automatic logic [3:0] dataBits(input logic [2:0] sz);
        // Sizes 0..3 give 5..8 bits; 7 gives nine; others treated as eight
        if (sz == `SIZE_NINE) begin
            dataBits = 4'h9;
        end else if (sz[2]) begin
            dataBits = 4'h8;
        end else begin
            dataBits = 4'h5 + {2'h0, sz[1:0]};
        end
    endfunction

    function automatic logic parityOf(input logic [8:0] d, input logic [3:0] n,
                                      input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                p = p ^ d[i];
            end
        end
        parityOf = p; // RULE13
    endfunction

    // ======================================================
    // Registers
    logic transmit_enable_bit_q, rxEn_q, ninth_q, master_q, dbl_q;
    logic [2:0] size_q;
    logic [1:0] parMode_q;
    logic stop2_q, sync_q, pol_q;
    logic [BAUD_W-1:0] baud_q;
    logic [8:0] buf_q;
    logic bufFull_q, txc_q, rxc_q, fe_q;
    logic [8:0] rxData_q;

    logic wrAcc, rdAcc, baudLoad;
    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = psel && penable && !pwrite;
    assign baudLoad = wrAcc && paddr == `ADDR_BAUD;

    logic moveToShift;
    logic frameDone;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            transmit_enable_bit_q <= 1'b0;
            rxEn_q <= 1'b0;
            ninth_q <= 1'b0;
            master_q <= 1'b0;
            dbl_q <= 1'b0;
            size_q <= `SIZE_RESET;
            parMode_q <= 2'h0;
            stop2_q <= 1'b0;
            sync_q <= 1'b0;
            pol_q <= 1'b0;
            baud_q <= BAUD_W'(`BAUD_RESET);
        end else if (wrAcc) begin
            unique case (paddr)
                `ADDR_CTRL: begin
                    transmit_enable_bit_q <= pwdata[`CT_TRANSMIT_ENABLE_BIT]; // RULE16
                    rxEn_q <= pwdata[`CT_RXEN];
                    ninth_q <= pwdata[`CT_NINTH]; // RULE26
                    master_q <= pwdata[`CT_MASTER];
                end
                `ADDR_STATUS: dbl_q <= pwdata[`ST_DBL];
                `ADDR_FORMAT: begin
                    size_q <= pwdata[`FM_SIZE_LO +: 3]; // RULE8
                    parMode_q <= pwdata[`FM_PAR_LO +: 2]; // RULE9
                    stop2_q <= pwdata[`FM_STOP]; // RULE10
                    sync_q <= pwdata[`FM_SYNC];
                    pol_q <= pwdata[`FM_POL];
                end
                `ADDR_BAUD: baud_q <= pwdata[BAUD_W-1:0];
                default: ;
            endcase
        end
    end

    // Data buffer: write loads it, upper bits beyond size dropped at shift load
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buf_q <= 9'h000;
            bufFull_q <= 1'b0;
        end else if (wrAcc && paddr == `ADDR_DATA) begin
            buf_q <= {ninth_q, pwdata[7:0]}; // RULE18
            bufFull_q <= 1'b1; // RULE25
        end else if (moveToShift) begin
            bufFull_q <= 1'b0; // RULE22
        end
    end

    // ======================================================
    // Baud generator and bit clock
    logic [BAUD_W-1:0] baudCnt_q;
    logic baudTick;
    assign baudTick = baudCnt_q == '0;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            baudCnt_q <= '0;
        end else if (baudLoad || baudTick) begin
            baudCnt_q <= baudLoad ? pwdata[BAUD_W-1:0] : baud_q; // RULE23
        end else begin
            baudCnt_q <= baudCnt_q - 1'b1;
        end
    end

    logic [4:0] div;
    assign div = sync_q ? `DIV_SYNC : (dbl_q ? `DIV_DOUBLE : `DIV_ASYNC); // RULE24
    logic [4:0] pre_q;
    logic intTick;
    assign intTick = baudTick && pre_q == div - 5'h1;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= 5'h00;
        end else if (baudTick) begin
            pre_q <= (pre_q >= div - 5'h1) ? 5'h00 : pre_q + 5'h1; // RULE23
        end
    end

    // Master clock: toggles halfway; runs freely in sync master mode, resets low for either polarity
    logic xckInt_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xckInt_q <= 1'b0;
        end else if (baudTick && sync_q && master_q) begin
            xckInt_q <= ~xckInt_q;
        end
    end

    // Pin inputs through two flops; edge detect on second stage only
    logic [1:0] xckSync_q, rxdSync_q;
    logic xckPrev_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xckSync_q <= 2'b00;
            rxdSync_q <= 2'b11;
            xckPrev_q <= 1'b0;
        end else begin
            xckSync_q <= {xckSync_q[0], xferClockIn};
            rxdSync_q <= {rxdSync_q[0], serialInPin};
            xckPrev_q <= xckSync_q[1];
        end
    end

    logic xckNow, xckWas, riseEdge, fallEdge, changeEdge, sampleEdge;
    assign xckNow = master_q ? xckInt_q : xckSync_q[1]; // RULE1
    logic xckOutPrev_q;
    assign xckWas = master_q ? xckOutPrev_q : xckPrev_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xckOutPrev_q <= 1'b0;
        end else begin
            xckOutPrev_q <= xckInt_q;
        end
    end
    assign riseEdge = xckNow && !xckWas;
    assign fallEdge = !xckNow && xckWas;
    assign changeEdge = pol_q ? fallEdge : riseEdge; // RULE3
    assign sampleEdge = pol_q ? riseEdge : fallEdge; // RULE2

    logic txTick, rxTick;
    assign txTick = sync_q ? changeEdge : intTick; // RULE20
    assign rxTick = sync_q ? sampleEdge : intTick;

    // ======================================================
    // Transmitter
    tx_state_t txSt_q;
    logic [9:0] shift_q;
    logic [3:0] bitCnt_q;
    logic stopCnt_q;
    logic txd_q;
    logic [3:0] nBits;
    assign nBits = dataBits(size_q); // RULE4

    assign frameDone = txSt_q == TX_STOP && txTick && (stopCnt_q || !stop2_q);
    assign moveToShift = bufFull_q && transmit_enable_bit_q && txTick &&
                         (txSt_q == TX_IDLE || frameDone); // RULE19

    function automatic logic [9:0] frameBits(input logic [8:0] d, input logic [3:0] n,
                                             input logic [1:0] pm);
        logic [9:0] f;
        f = 10'h000;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                f[i] = d[i]; // RULE21
            end
        end
        f[n] = parityOf(d, n, pm[0]); // RULE9
        frameBits = f;
    endfunction

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txSt_q <= TX_IDLE;
            shift_q <= 10'h000;
            bitCnt_q <= 4'h0;
            stopCnt_q <= 1'b0;
            txd_q <= 1'b1;
        end else if (txTick) begin
            unique case (txSt_q)
                TX_IDLE, TX_STOP: begin
                    if (moveToShift) begin
                        shift_q <= frameBits(buf_q, nBits, parMode_q);
                        txd_q <= 1'b0; // RULE6
                        txSt_q <= TX_START; // RULE7
                    end else if (txSt_q == TX_STOP && !frameDone) begin
                        stopCnt_q <= 1'b1;
                        txd_q <= 1'b1;
                    end else begin
                        txd_q <= 1'b1; // RULE27
                        txSt_q <= TX_IDLE;
                    end
                end
                TX_START, TX_BITS: begin
                    if (txSt_q == TX_START) begin
                        bitCnt_q <= 4'h0;
                    end
                    if (txSt_q == TX_BITS &&
                        bitCnt_q == nBits - (parMode_q[1] ? 4'h0 : 4'h1)) begin
                        txd_q <= 1'b1; // RULE6
                        stopCnt_q <= 1'b0;
                        txSt_q <= TX_STOP;
                    end else begin
                        txd_q <= shift_q[0]; // RULE5
                        shift_q <= {1'b0, shift_q[9:1]};
                        bitCnt_q <= (txSt_q == TX_START) ? 4'h0 : bitCnt_q + 4'h1;
                        txSt_q <= TX_BITS;
                    end
                end
                default: txSt_q <= TX_IDLE;
            endcase
        end
    end

    // Complete flag: set wins over software clear-by-one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txc_q <= 1'b0;
        end else if (frameDone && !bufFull_q) begin
            txc_q <= 1'b1;
        end else if (wrAcc && paddr == `ADDR_STATUS && pwdata[`ST_TXC]) begin
            txc_q <= 1'b0; // RULE15
        end
    end

    // ======================================================
    // Receiver framing: checks only first stop bit
    rx_state_t rxSt_q;
    logic [3:0] rxCnt_q;
    logic [8:0] rxSh_q;
    logic [3:0] rxLast;
    assign rxLast = nBits - (parMode_q[1] ? 4'h0 : 4'h1); // RULE11
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxSt_q <= RX_IDLE;
            rxCnt_q <= 4'h0;
            rxSh_q <= 9'h000;
            rxData_q <= 9'h000;
            rxc_q <= 1'b0;
            fe_q <= 1'b0;
        end else begin
            if (rdAcc && paddr == `ADDR_DATA) begin
                rxc_q <= 1'b0;
            end
            if (rxEn_q && rxTick) begin
                unique case (rxSt_q)
                    RX_IDLE: begin
                        if (!rxdSync_q[1]) begin
                            rxCnt_q <= 4'h0;
                            rxSt_q <= RX_BITS;
                        end
                    end
                    RX_BITS: begin
                        if (4'(rxCnt_q) < nBits) begin
                            rxSh_q[rxCnt_q] <= rxdSync_q[1];
                        end
                        rxCnt_q <= rxCnt_q + 4'h1;
                        if (rxCnt_q == rxLast) begin
                            rxSt_q <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        fe_q <= !rxdSync_q[1]; // RULE12
                        rxData_q <= rxSh_q;
                        rxc_q <= 1'b1;
                        rxSt_q <= RX_IDLE; // RULE10
                    end
                    default: rxSt_q <= RX_IDLE;
                endcase
            end
        end
    end

    // ======================================================
    // Pins and bus answer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serialOutPin <= 1'b1;
            serialOutOe <= 1'b0;
            xferClockOut <= 1'b0;
            xferClockOe <= 1'b0;
        end else begin
            serialOutPin <= txd_q;
            serialOutOe <= transmit_enable_bit_q || txSt_q != TX_IDLE; // RULE16
            xferClockOut <= xckInt_q;
            xferClockOe <= sync_q && master_q && transmit_enable_bit_q; // RULE17
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `ADDR_DATA: prdata <= {23'h0, rxData_q};
                    `ADDR_STATUS: prdata <= {27'h0, dbl_q, fe_q, rxc_q, txc_q, !bufFull_q};
                    `ADDR_CTRL: prdata <= {28'h0, master_q, ninth_q, rxEn_q, transmit_enable_bit_q};
                    `ADDR_FORMAT: prdata <= {24'h0, pol_q, sync_q, stop2_q, parMode_q, size_q};
                    `ADDR_BAUD: prdata <= 32'(baud_q);
                    default: pslverr <= 1'b1;
                endcase
            end else if (psel && !penable) begin
                pslverr <= !(paddr inside {`ADDR_DATA, `ADDR_STATUS, `ADDR_CTRL,
                                           `ADDR_FORMAT, `ADDR_BAUD});
            end
        end
    end
endmodule

/* File: tb/usart_peer_model.sv */
`timescale 1ns/1ps
module usart_peer_model (
    // Clock
    input wire logic clk,
    // Line from the device
    input wire logic serialOutPin,
    input wire logic serialOutOe,
    // Expected line format
    input wire logic [5:0] bitClks,
    input wire logic [3:0] nData,
    input wire logic parOn,
    input wire logic [1:0] nStop,
    // Back to the device
    output logic serialInPin,
    output logic xferClockIn,
    // Decoded frame
    output logic gotFrame,
    output logic [8:0] gotData,
    output logic gotPar,
    output logic stopOk,
    output int gap
);
    logic line;
    int cyc = 0;
    int tEnd = 0;
    // A released pin floats to its pull-up level
    assign line = serialOutOe ? serialOutPin : 1'h1;
    assign serialInPin = 1'h1;
    // Slave clock stands still, so nothing shifts in slave mode
    assign xferClockIn = 1'h0;
    always @(posedge clk) cyc <= cyc + 1;
    initial begin
        gotFrame = 1'h0;
        forever begin
            @(posedge clk);
            gotFrame <= 1'h0;
            if (line === 1'h0) begin
                gap = cyc - tEnd;
                repeat (bitClks / 2) @(posedge clk);
                gotData = 9'h000;
                for (int i = 0; i < nData; i++) begin
                    repeat (bitClks) @(posedge clk);
                    gotData[i] = line;
                end
                if (parOn) begin
                    repeat (bitClks) @(posedge clk);
                    gotPar = line;
                end
                stopOk = 1'h1;
                for (int i = 0; i < nStop; i++) begin
                    repeat (bitClks) @(posedge clk);
                    stopOk = stopOk & line;
                end
                tEnd = cyc + bitClks / 2;
                gotFrame <= 1'h1;
            end
        end
    end
endmodule

/* File: tb/usart_sync_framing_tx_tb_top.sv */
`timescale 1ns/1ps
`include "usart_sync_map.svh"
module usart_sync_framing_tx_tb_top;
    import usart_sync_pkg::*;
    typedef struct {logic [8:0] d; logic p; bit g;} note_t;
    logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    word_t pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, serialInPin, serialOutPin, serialOutOe;
    logic xferClockIn, xferClockOut, xferClockOe, gotFrame, gotPar, stopOk;
    logic [8:0] gotData;
    logic [5:0] bitClks = 6'h10;
    logic [3:0] nData = 4'h8;
    logic [1:0] nStop = 2'h1;
    logic parOn = 1'h0, odd = 1'h0, dbl = 1'h0;
    // Upper format bits {polarity, sync}; sync runs always as master here
    logic [1:0] fmtHi = 2'h0;
    int gap, nFail = 0, checksDone = 0;
    note_t expQ[$];
    always #25 clk = ~clk;
    usart_sync_framing_tx #(.BAUD_W(12)) u_usart_sync_framing_tx (.clk(clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .serialInPin(serialInPin),
        .serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .xferClockIn(xferClockIn),
        .xferClockOut(xferClockOut), .xferClockOe(xferClockOe));
    usart_peer_model u_usart_peer_model (.clk(clk), .serialOutPin(serialOutPin),
        .serialOutOe(serialOutOe), .bitClks(bitClks), .nData(nData), .parOn(parOn),
        .nStop(nStop), .serialInPin(serialInPin), .xferClockIn(xferClockIn),
        .gotFrame(gotFrame), .gotData(gotData), .gotPar(gotPar), .stopOk(stopOk), .gap(gap));
    // ==========
    // Checks and closing
    task automatic cmp(input word_t got, input word_t exp);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmpFrame(input note_t e);
        checksDone++;
        if (gotData !== e.d || (parOn && gotPar !== e.p) || stopOk !== 1'h1 || (e.g && gap != 0))
        begin
            nFail++;
            $display("wrong value at %0t: frame %h want %h gap %0d", $time, gotData, e.d, gap);
        end
    endtask
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (gotFrame === 1'h1) begin
            if (expQ.size() == 0) begin
                nFail++;
                $display("wrong value at %0t: unexpected frame", $time);
            end else begin
                cmpFrame(expQ.pop_front());
            end
        end
    end
    // ==========
    // Bus tasks
    task automatic apb(input logic w, input logic [11:0] a, input word_t d);
        int n;
        n = 0;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) nFail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic waitBit(input int b);
        int n;
        n = 0;
        do begin
            apb(1'h0, `ADDR_STATUS, 32'h0);
            n++;
        end while (rd[b] !== 1'h1 && n < 400);
        if (rd[b] !== 1'h1) nFail++;
    endtask
    // Waits for the line to go quiet, then clears transmit complete
    task automatic drain();
        waitBit(`ST_TXC);
        apb(1'h1, `ADDR_STATUS, 32'h2 | (dbl ? 32'h10 : 32'h0));
    endtask
    task automatic setFmt(input logic [2:0] sz, input logic [1:0] pm, input logic st);
        apb(1'h1, `ADDR_FORMAT, {24'h0, fmtHi, st, pm, sz});
        nData = (sz == `SIZE_NINE) ? 4'h9 : 4'(sz) + 4'h5;
        parOn = pm[1];
        odd = pm[0];
        nStop = 2'(st) + 2'h1;
    endtask
    task automatic send(input logic [8:0] d, input bit g);
        note_t e;
        waitBit(`ST_BUFEMPTY);
        apb(1'h1, `ADDR_CTRL, {28'h0, fmtHi[0], d[8], 2'h1});
        e.d = d & 9'((1 << nData) - 1);
        e.p = ^e.d ^ odd;
        e.g = g;
        expQ.push_back(e);
        apb(1'h1, `ADDR_DATA, {24'h0, d[7:0]});
    endtask
    // ==========
    // Scenarios
    initial begin
        repeat (60000) @(posedge clk);
        nFail++;
        reportAndStop();
    end
    initial begin
        void'($urandom(12));
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        apb(1'h0, `ADDR_FORMAT, 32'h0);
        cmp(rd & 32'h7, 32'h3);
        apb(1'h0, `ADDR_STATUS, 32'h0);
        cmp(rd & 32'h1, 32'h1);
        apb(1'h1, 12'h020, $urandom);
        cmp(word_t'(err), 32'h1);
        cmp(word_t'(serialOutOe), 32'h0);
        apb(1'h1, `ADDR_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        cmp(word_t'(serialOutOe), 32'h1);
        cmp(word_t'(serialOutPin), 32'h1);
        for (int i = 0; i < 30; i++) begin
            setFmt(i / 6 == 4 ? `SIZE_NINE : 3'(i / 6), (i % 3 == 0) ? 2'h0 : 2'(i % 3 + 1),
                1'(i / 3 % 2));
            send(9'($urandom), 1'b0);
            drain();
        end
        send(9'($urandom), 1'b0);
        send(9'($urandom), 1'b1);
        apb(1'h0, `ADDR_STATUS, 32'h0);
        cmp(rd & 32'h1, 32'h0);
        drain();
        dbl = 1'h1;
        apb(1'h1, `ADDR_STATUS, 32'h10);
        bitClks = 6'h08;
        send(9'($urandom), 1'b0);
        drain();
        dbl = 1'h0;
        apb(1'h1, `ADDR_STATUS, 32'h0);
        apb(1'h1, `ADDR_BAUD, 32'h1);
        bitClks = 6'h20;
        send(9'($urandom), 1'b0);
        drain();
        // Sync master with divisor 1: clock period and bit period are four clocks
        bitClks = 6'h04;
        for (int p = 0; p < 2; p++) begin
            fmtHi = {1'(p), 1'h1};
            setFmt(3'h3, 2'h2 | 2'(p), 1'(p));
            apb(1'h1, `ADDR_CTRL, 32'h9);
            repeat (2) @(posedge clk);
            cmp(word_t'(xferClockOe), 32'h1);
            rd = word_t'(xferClockOut);
            repeat (2) @(posedge clk);
            cmp(word_t'(xferClockOut ^ rd[0]), 32'h1);
            send(9'($urandom), 1'b0);
            drain();
        end
        apb(1'h1, `ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        cmp(word_t'(xferClockOe), 32'h0);
        cmp(word_t'(serialOutOe), 32'h0);
        cmp(word_t'(expQ.size()), 32'h0);
        reportAndStop();
    end
endmodule
bind usart_sync_framing_tx usart_tx_checker #(.BAUD_W(BAUD_W)) u_usart_tx_checker (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .serialOutPin(serialOutPin), .serialOutOe(serialOutOe),
    .xferClockOe(xferClockOe));

/* File: tb/usart_tx_checker.sv */
`timescale 1ns/1ps
`include "usart_sync_map.svh"
module usart_tx_checker #(
    parameter int BAUD_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Serial
    input wire logic serialOutPin,
    input wire logic serialOutOe,
    input wire logic xferClockOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic mapped;
    assign mapped = paddr inside {`ADDR_DATA, `ADDR_STATUS, `ADDR_CTRL, `ADDR_FORMAT, `ADDR_BAUD};
    // ==========
    // Bus
    chk_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready late");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_err_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong");
    // ==========
    // Line
    chk_start_owned: assert property ($fell(serialOutPin) |-> serialOutOe)
        else $error("start bit on released pin");
    chk_release_high: assert property ($fell(serialOutOe) |-> $past(serialOutPin))
        else $error("pin released mid frame");
    chk_enable_idle: assert property ($rose(serialOutOe) |-> serialOutPin)
        else $error("pin low on enable");
    // Async bits last at least eight clocks, the double speed minimum
    chk_bit_width: assert property (
        $changed(serialOutPin) && serialOutOe && !xferClockOe |=> $stable(serialOutPin)[*7])
        else $error("bit too short");
    chk_clock_oe: assert property (xferClockOe |-> serialOutOe)
        else $error("clock driven without transmitter");
    cover property ($fell(serialOutPin));
    cover property (pslverr);
    cover property ($rose(xferClockOe));
endmodule
